/* core/stpcs_pkg.sv */
// Constants for the shared timer prescaler and clock select block.
// Assumes one 20 MHz system clock and a synchronous active-high reset.
package stpcs_pkg;
  localparam logic [5:0] CTRL_ADDR = 6'h20;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int HOLD_BIT = 7;
  localparam int SHARED_RST_BIT = 0;
  localparam int OTHER_RST_BIT = 1;
  localparam int NUM_COUNTERS = 3;
  localparam int DIV_WIDTH = 10;
  localparam logic [2:0] SEL_STOP = 3'h0;
  localparam logic [2:0] SEL_DIRECT = 3'h1;
  localparam logic [2:0] SEL_DIV8 = 3'h2;
  localparam logic [2:0] SEL_DIV64 = 3'h3;
  localparam logic [2:0] SEL_DIV256 = 3'h4;
  localparam logic [2:0] SEL_DIV1024 = 3'h5;
  localparam logic [2:0] SEL_PIN_FALL = 3'h6;
  localparam logic [2:0] SEL_PIN_RISE = 3'h7;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03f;
  localparam logic [9:0] MASK_DIV256 = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
endpackage

/* core/stpcs_clock_select.sv */
// One counter's clock select: pin sampling, edge detection and tap choice.
// Assumes taps come from the shared prescaler on the same clock.
module stpcs_clock_select
(
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic [2:0] select, // Clock source select code
  input wire logic [3:0] taps, // Prescaler tap pulses, 8 to 1024
  input wire logic pin, // Asynchronous external count pin
  output logic tick // Counter tick pulse
);
  logic sync_a;
  logic sync_b;
  logic sync_prev;
  logic pin_rise;
  logic pin_fall;
  logic next_tick;

  // Two flops on the rising edge stand in for latch plus flop; prev feeds the edge detector
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_prev <= 1'b0;
    end
    else
    begin
      sync_a <= pin;
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  assign pin_rise = sync_b & ~sync_prev;
  assign pin_fall = ~sync_b & sync_prev;

  // Source choice; pin edges bypass the divider entirely
  always_comb
  begin
    unique case (select)
      stpcs_pkg::SEL_STOP: next_tick = 1'b0;
      stpcs_pkg::SEL_DIRECT: next_tick = 1'b1;
      stpcs_pkg::SEL_DIV8: next_tick = taps[0];
      stpcs_pkg::SEL_DIV64: next_tick = taps[1];
      stpcs_pkg::SEL_DIV256: next_tick = taps[2];
      stpcs_pkg::SEL_DIV1024: next_tick = taps[3];
      stpcs_pkg::SEL_PIN_FALL: next_tick = pin_fall;
      stpcs_pkg::SEL_PIN_RISE: next_tick = pin_rise;
    endcase
  end

  // Direct mode must tick every cycle, so the tick is combinational
  assign tick = next_tick;

  a_stop_no_tick: assert property (@(posedge clk) disable iff (rst)
    select == stpcs_pkg::SEL_STOP |-> !tick) else $error("tick while stopped");
  a_rise_tick: assert property (@(posedge clk) disable iff (rst)
    select == stpcs_pkg::SEL_PIN_RISE && $rose(sync_b) |-> tick) else $error("rising edge missed");
  a_fall_tick: assert property (@(posedge clk) disable iff (rst)
    select == stpcs_pkg::SEL_PIN_FALL && $fell(sync_b) |-> tick) else $error("falling edge missed");
  // Pin edge sampled, then the select held while the edge crosses both flops
  sequence s_pin_rise_seen;
    (select == stpcs_pkg::SEL_PIN_RISE && $rose(pin)) ##1 select == stpcs_pkg::SEL_PIN_RISE [*2];
  endsequence
  sequence s_pin_fall_seen;
    (select == stpcs_pkg::SEL_PIN_FALL && $fell(pin)) ##1 select == stpcs_pkg::SEL_PIN_FALL [*2];
  endsequence

  // Latency is checked from the raw pin, so a lost or extra flop stage shows up
  a_pin_delay: assert property (@(posedge clk) disable iff (rst)
    s_pin_rise_seen |-> tick) else $error("rise edge latency wrong");
  a_fall_delay: assert property (@(posedge clk) disable iff (rst)
    s_pin_fall_seen |-> tick) else $error("fall edge latency wrong");
endmodule

/* core/stpcs_prescaler.sv */
// Top: shared free-running prescaler, control register and three clock selects.
// Assumes a simple 8-bit I/O register port on the system clock.
module stpcs_prescaler
(
  input wire logic CLOCK, // System clock, 20 MHz
  input wire logic RESET, // Synchronous reset, active high
  input wire logic [5:0] IO_ADDR, // I/O register address
  input wire logic IO_WRITE, // Write strobe
  input wire logic IO_READ, // Read strobe
  input wire logic [7:0] IO_WDATA, // Write data
  output logic [7:0] IO_RDATA, // Read data, registered
  input wire logic [2:0] COUNTER_CLOCK_SOURCE_SELECT [3], // Per-counter select code
  input wire logic [2:0] EXTERNAL_COUNT_PIN, // Asynchronous count pins
  output logic [2:0] COUNTER_TICK, // Per-counter tick pulses
  output logic OTHER_DIVIDER_RESET // Reset bit for the separate prescaler
);
  logic [stpcs_pkg::DIV_WIDTH-1:0] divider;
  logic hold_mode;
  logic shared_divider_reset;
  logic other_reset;
  logic ctrl_write;
  logic [3:0] taps;
  logic [7:0] ctrl_value;
  logic [7:0] next_rdata;

  assign ctrl_write = IO_WRITE && (IO_ADDR == stpcs_pkg::CTRL_ADDR);
  assign ctrl_value = {hold_mode, 5'h00, other_reset, shared_divider_reset};
  assign next_rdata = (IO_READ && IO_ADDR == stpcs_pkg::CTRL_ADDR) ? ctrl_value : 8'h00;

  // Control register: reset bits latch only while hold mode is on
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      hold_mode <= stpcs_pkg::CTRL_RESET[stpcs_pkg::HOLD_BIT];
      shared_divider_reset <= stpcs_pkg::CTRL_RESET[stpcs_pkg::SHARED_RST_BIT];
      other_reset <= stpcs_pkg::CTRL_RESET[stpcs_pkg::OTHER_RST_BIT];
    end
    else if (ctrl_write)
    begin
      hold_mode <= IO_WDATA[stpcs_pkg::HOLD_BIT];
      shared_divider_reset <= IO_WDATA[stpcs_pkg::HOLD_BIT] & IO_WDATA[stpcs_pkg::SHARED_RST_BIT];
      other_reset <= IO_WDATA[stpcs_pkg::HOLD_BIT] & IO_WDATA[stpcs_pkg::OTHER_RST_BIT];
    end
    else if (!hold_mode)
    begin
      shared_divider_reset <= 1'b0;
      other_reset <= 1'b0;
    end
  end

  // A pulsed write without hold mode must still reset the divider this cycle
  logic divider_clear;
  assign divider_clear = shared_divider_reset | (ctrl_write & IO_WDATA[stpcs_pkg::SHARED_RST_BIT]);

  // Free-running divider, blind to every counter's select
  always_ff @(posedge CLOCK)
  begin
    if (RESET || divider_clear)
      divider <= '0;
    else
      divider <= divider + 10'h001;
  end

  // Tap pulses fire when the low bits wrap; phase gives 1 to N+1 latency
  assign taps[0] = !divider_clear && (divider & stpcs_pkg::MASK_DIV8) == stpcs_pkg::MASK_DIV8;
  assign taps[1] = !divider_clear && (divider & stpcs_pkg::MASK_DIV64) == stpcs_pkg::MASK_DIV64;
  assign taps[2] = !divider_clear && (divider & stpcs_pkg::MASK_DIV256) == stpcs_pkg::MASK_DIV256;
  assign taps[3] = !divider_clear && divider == stpcs_pkg::MASK_DIV1024;

  // Read data and the other reset come from flops
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      IO_RDATA <= 8'h00;
    else
      IO_RDATA <= next_rdata;
  end
  assign OTHER_DIVIDER_RESET = other_reset;

  // One select unit per counter, all sharing one divider
  genvar g;
  for (g = 0; g < stpcs_pkg::NUM_COUNTERS; g++)
  begin : g_sel
    stpcs_clock_select u_sel
    (
      .clk(CLOCK),
      .rst(RESET),
      .select(COUNTER_CLOCK_SOURCE_SELECT[g]),
      .taps(taps),
      .pin(EXTERNAL_COUNT_PIN[g]),
      .tick(COUNTER_TICK[g])
    );
  end

  // A plain reset write must restart the divider and leave no bit standing
  a_selfclear: assert property (@(posedge CLOCK) disable iff (RESET)
    ctrl_write && IO_WDATA[stpcs_pkg::SHARED_RST_BIT] && !IO_WDATA[stpcs_pkg::HOLD_BIT]
    |=> divider == 10'h000 && !shared_divider_reset) else $error("reset bit stuck");
  a_hold_write: assert property (@(posedge CLOCK) disable iff (RESET)
    ctrl_write && IO_WDATA[stpcs_pkg::HOLD_BIT] && IO_WDATA[stpcs_pkg::SHARED_RST_BIT]
    |=> hold_mode && shared_divider_reset) else $error("held reset not taken");
  a_hold_keeps: assert property (@(posedge CLOCK) disable iff (RESET)
    hold_mode && !ctrl_write && shared_divider_reset |=> shared_divider_reset) else $error("held reset lost");
  a_release_both: assert property (@(posedge CLOCK) disable iff (RESET)
    ctrl_write && !IO_WDATA[stpcs_pkg::HOLD_BIT] |=> !shared_divider_reset && !other_reset)
    else $error("release incomplete");
  a_div_cleared: assert property (@(posedge CLOCK) disable iff (RESET)
    divider_clear |=> divider == 10'h000) else $error("divider not restarted");
  // A tap, or a divider restart, followed by eight undisturbed cycles
  sequence s_tap8_then_quiet;
    taps[0] ##1 !divider_clear [*8];
  endsequence
  sequence s_clear_then_quiet;
    divider_clear ##1 !divider_clear [*8];
  endsequence

  a_div8_period: assert property (@(posedge CLOCK) disable iff (RESET)
    s_tap8_then_quiet |-> taps[0]) else $error("div8 period wrong");
  a_tap_nest: assert property (@(posedge CLOCK) disable iff (RESET)
    taps[3] |-> taps[2] && taps[1] && taps[0]) else $error("taps out of step");
  // Held reset must silence every tap, not only the divider count
  a_taps_quiet: assert property (@(posedge CLOCK) disable iff (RESET)
    divider_clear |-> taps == 4'h0) else $error("tap during divider reset");
  a_div_runs: assert property (@(posedge CLOCK) disable iff (RESET)
    !divider_clear |=> divider == $past(divider) + 10'h001) else $error("divider stalled");
  a_tap8_first: assert property (@(posedge CLOCK) disable iff (RESET)
    s_clear_then_quiet |-> taps[0]) else $error("first tick late");
  a_direct_tick: assert property (@(posedge CLOCK) disable iff (RESET)
    COUNTER_CLOCK_SOURCE_SELECT[0] == stpcs_pkg::SEL_DIRECT |-> COUNTER_TICK[0]) else $error("direct tick missing");
endmodule

/* sim/stpcs_pin_model.sv */
// Partner: source of the three external count pins.
// Assumes the bench asks for a level on falling edges; the pin moves 1 ns later.
module stpcs_pin_model
(
  input wire logic clk, // System clock
  input wire logic [2:0] want, // Level asked for by the bench
  output logic [2:0] pin // Count pins
);
  timeunit 1ns;
  timeprecision 1ns;
  int age = 0;
  initial pin = 3'h0;
  // Each level held three cycles at least, slower than clock over 2.5
  always @(negedge clk)
  begin
    #1;
    age++;
    if (want != pin && age >= 3)
    begin
      pin = want;
      age = 0;
    end
  end
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the shared prescaler and its three clock selects.
// Assumes a 20 MHz clock; every input moves on falling edges only.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] addr = 6'h20;
  logic [7:0] wdata = 8'h00;
  logic [2:0] sel [3] = '{3'h0, 3'h0, 3'h0};
  logic [2:0] want = 3'h0;
  logic [7:0] rdata;
  logic [2:0] pins;
  logic [2:0] tick;
  logic other_rst;
  int n_mismatch = 0;
  int samples_checked = 0;
  int c [3];
  int first [3];
  int div [4] = '{8, 64, 256, 1024};
  stpcs_prescaler dut_u (.CLOCK(clock), .RESET(reset), .IO_ADDR(addr), .IO_WRITE(wr), .IO_READ(rd),
    .IO_WDATA(wdata), .IO_RDATA(rdata), .COUNTER_CLOCK_SOURCE_SELECT(sel), .EXTERNAL_COUNT_PIN(pins),
    .COUNTER_TICK(tick), .OTHER_DIVIDER_RESET(other_rst));
  stpcs_pin_model pin_u (.clk(clock), .want(want), .pin(pins));
  // 25 ns half period
  initial
  begin
    forever #25 clock = ~clock;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // One access; read data is registered, so looked at one cycle on
  task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clock);
    wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [5:0] a, input logic [7:0] exp);
    io(1'b0, a, 8'h00);
    chk(what, exp, rdata);
  endtask
  // Ticks per counter over n cycles, and the cycle of each first tick
  task automatic cnt(input int n);
    c = '{0, 0, 0};
    first = '{0, 0, 0};
    for (int k = 1; k <= n; k++)
    begin
      @(negedge clock);
      for (int j = 0; j < 3; j++)
        if (tick[j] === 1'b1)
        begin
          first[j] = (c[j] == 0) ? k : first[j];
          c[j]++;
        end
    end
  endtask
  task automatic t_regs;
    rdchk("ctrl reset", 6'h20, 8'h00);
    rdchk("unmapped", 6'h21, 8'h00);
    io(1'b1, 6'h20, 8'h01);
    rdchk("self clear", 6'h20, 8'h00);
    io(1'b1, 6'h20, 8'hff);
    rdchk("hold keeps", 6'h20, 8'h83);
    chk("other reset", 1, other_rst);
    io(1'b1, 6'h20, 8'h00);
    rdchk("release", 6'h20, 8'h00);
    chk("other reset off", 0, other_rst);
    $display("t_regs done");
  endtask
  task automatic t_taps;
    for (int k = 0; k < 4; k++)
    begin
      sel = '{3'h2 + 3'(k), 3'h2 + 3'(k), 3'h1};
      cnt(4 * div[k]);
      chk("tap ticks", 4, c[0]);
      chk("first tick", 1, first[0] >= 1 && first[0] <= div[k] + 1);
      chk("shared phase", first[0], first[1]);
      chk("direct ticks", 4 * div[k], c[2]);
    end
    sel = '{3'h0, 3'h0, 3'h0};
    cnt(40);
    chk("stopped", 0, c[0] + c[1] + c[2]);
    $display("t_taps done");
  endtask
  task automatic t_prst;
    sel = '{3'h2, 3'h2, 3'h0};
    io(1'b1, 6'h20, 8'h01);
    cnt(10);
    chk("restart", 1, first[0] == first[1] && first[0] >= 7 && first[0] <= 9);
    io(1'b1, 6'h20, 8'h81);
    cnt(40);
    chk("held", 0, c[0] + c[1]);
    io(1'b1, 6'h20, 8'h00);
    cnt(10);
    chk("resume", 1, first[0] == first[1] && first[0] >= 7 && first[0] <= 9);
    $display("t_prst done");
  endtask
  // Reset in mid-run drops hold mode and restarts the divider from zero
  task automatic t_rst;
    sel = '{3'h2, 3'h2, 3'h0};
    io(1'b1, 6'h20, 8'h83);
    @(negedge clock);
    reset = 1'b1;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    cnt(10);
    chk("reset restart", 1, first[0] == first[1] && first[0] >= 7 && first[0] <= 9);
    chk("reset stop", 0, c[2]);
    rdchk("reset ctrl", 6'h20, 8'h00);
    chk("reset other", 0, other_rst);
    $display("t_rst done");
  endtask
  // Pin has been still for cycles when the select changes; all three pins move
  task automatic t_pin(input logic [2:0] code);
    sel = '{code, code, code};
    want = 3'h7;
    cnt(8);
    for (int j = 0; j < 3; j++)
    begin
      chk("rise ticks", code == 3'h7, c[j]);
      if (code == 3'h7)
        chk("rise delay", 1, first[j] >= 2 && first[j] <= 3);
    end
    want = 3'h0;
    cnt(8);
    for (int j = 0; j < 3; j++)
      chk("fall ticks", code == 3'h6, c[j]);
    $display("t_pin done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Reset for 16 cycles, then each scenario in turn
  initial
  begin
    repeat (16) @(negedge clock);
    reset = 1'b0;
    t_regs();
    t_taps();
    t_prst();
    t_rst();
    t_pin(3'h7);
    t_pin(3'h6);
    summarize();
  end
endmodule
